// ### design/rsa_rtc_serial.v
// Two-wire slave port and clock/calendar register file of a real-time clock
// Assumes scl/sda inputs synchronous to clock; sda pin resolved outside from sda_out/sda_oe
// Contract
// - Device is a slave only; access by START plus fixed address D0h.
// - Twenty byte registers in fixed sequential order.
// - Supply below switchover aborts transfer, clears pointer, ignores bus.
// - Data falling while clock high is START.
// - Data rising while clock high is STOP, ending transfer.
// - Data changes only while clock low; one clock pulse per bit.
// - Eight-bit bytes, ninth acknowledge bit, unlimited byte count.
// - Acknowledger holds data low through acknowledge clock high phase.
// - Master withholds final acknowledge on read; slave releases data.
// - Addressed read: word address write, repeated START, read address.
// - Pointer advances by one only on acknowledge clock.
// - Sequential reads continue while master acknowledges until STOP.
// - User copy frozen while pointer holds clock address during a transfer.
// - Read without address write starts at current pointer.
// - First written byte loads pointer; later bytes stored then pointer advances.
// - Acknowledge matching address, word address and every written byte.
// - Writes blocked for recovery interval after supply returns.
// - Sub-second register accepts only zero writes.
// - Century flag inverts at century rollover when enabled.
// - Day of week low three bits; date, month, year in BCD.
// - Seconds top bit halts oscillator; clearing restarts within a second.
// - Any completed clock-address write resets divider chain.
`timescale 1ns/1ps
`include "rsa_defines.vh"

module rsa_rtc_serial #(
  parameter REC_CYCLES = `RSA_REC_CYCLES,
  parameter TICK_DIV = `RSA_TICK_DIV
) (
  input wire clock,
  input wire resetn,
  input wire scl_in,
  input wire sda_in,
  input wire supply_low,
  output reg sda_out,
  output reg sda_oe,
  output reg bus_blocked,
  output reg [4:0] word_address_value
);

  // ****************************************
  // Helpers
  // ****************************************
  function [7:0] bcd_inc;
    input [7:0] v;
    begin
      if (v[3:0] == 4'h9)
        bcd_inc = {v[7:4] + 4'h1, 4'h0};
      else
        bcd_inc = {v[7:4], v[3:0] + 4'h1};
    end
  endfunction

  function [4:0] ptr_inc;
    input [4:0] p;
    begin
      if (p == `RSA_REG_LAST)
        ptr_inc = 5'h00;
      else
        ptr_inc = p + 5'h01;
    end
  endfunction

  function [7:0] month_days;
    input [7:0] m;
    input [7:0] y;
    begin
      case (m)
        8'h04, 8'h06, 8'h09, 8'h11: month_days = 8'h30;
        8'h02: month_days = (y[4] ^ y[1] ^ y[0]) ? 8'h28 :
                            ((y[4] ? (y[3:0] == 4'h2 || y[3:0] == 4'h6) :
                              (y[3:0] == 4'h0 || y[3:0] == 4'h4 || y[3:0] == 4'h8)) ? 8'h29 : 8'h28);
        default: month_days = 8'h31;
      endcase
    end
  endfunction

  // ****************************************
  // Line sampling and bus conditions
  // ****************************************
  reg scl_d;
  reg sda_d;
  wire scl_rise = scl_in & ~scl_d;
  wire scl_fall = ~scl_in & scl_d;
  wire start_cond = scl_in & scl_d & sda_d & ~sda_in;
  wire stop_cond = scl_in & scl_d & ~sda_d & sda_in;

  // Delayed line copies reset to the idle level so release shows no false edge
  always @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      scl_d <= 1'b1;
      sda_d <= 1'b1;
    end else begin
      scl_d <= scl_in;
      sda_d <= sda_in;
    end
  end

  // ****************************************
  // Supply monitor and recovery block
  // ****************************************
  reg [31:0] rec_count;
  wire link_off = supply_low | bus_blocked;

  always @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      rec_count <= 32'h00000000;
      bus_blocked <= 1'b1;
    end else if (supply_low) begin
      rec_count <= 32'h00000000;
      bus_blocked <= 1'b1;
    end else if (rec_count < REC_CYCLES) begin
      rec_count <= rec_count + 32'h00000001;
      bus_blocked <= 1'b1;
    end else begin
      bus_blocked <= 1'b0;
    end
  end

  // ****************************************
  // Slave state machine
  // ****************************************
  localparam ST_IDLE = 6'b000001;
  localparam ST_DEVADDR = 6'b000010;
  localparam ST_ACK = 6'b000100;
  localparam ST_RXBYTE = 6'b001000;
  localparam ST_TXBYTE = 6'b010000;
  localparam ST_MACK = 6'b100000;

  reg [5:0] state;
  reg [3:0] bit_count;
  reg [7:0] shift;
  reg reading;
  reg have_addr;
  reg ack_drive;
  reg [7:0] user_reg [0:19];
  reg [7:0] tx_byte;
  reg wr_pulse;
  reg [4:0] wr_addr;
  reg [7:0] wr_data;

  // Two-entry buffer between the link side and the register file
  reg [7:0] buf_data [0:1];
  reg [4:0] buf_addr [0:1];
  reg [1:0] buf_cnt;
  reg buf_wp;
  reg buf_rp;
  wire buf_in_ready = (buf_cnt != 2'd2);
  wire buf_out_valid = (buf_cnt != 2'd0);
  wire buf_out_ready = 1'b1;
  wire push = wr_pulse & buf_in_ready;
  wire pop = buf_out_valid & buf_out_ready;

  always @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      buf_cnt <= 2'd0;
      buf_wp <= 1'b0;
      buf_rp <= 1'b0;
    end else begin
      if (push) begin
        buf_data[buf_wp] <= wr_data;
        buf_addr[buf_wp] <= wr_addr;
        buf_wp <= ~buf_wp;
      end
      if (pop)
        buf_rp <= ~buf_rp;
      buf_cnt <= buf_cnt + {1'b0, push} - {1'b0, pop};
    end
  end

  always @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      state <= ST_IDLE;
      bit_count <= 4'h0;
      shift <= `RSA_RESET_BYTE;
      reading <= 1'b0;
      have_addr <= 1'b0;
      ack_drive <= 1'b0;
      word_address_value <= 5'h00;
      sda_out <= 1'b1;
      sda_oe <= 1'b0;
      wr_pulse <= 1'b0;
      wr_addr <= 5'h00;
      wr_data <= `RSA_RESET_BYTE;
    end else begin
      wr_pulse <= 1'b0;
      if (link_off) begin
        state <= ST_IDLE;
        word_address_value <= 5'h00;
        sda_oe <= 1'b0;
      end else if (stop_cond) begin
        state <= ST_IDLE;
        sda_oe <= 1'b0;
      end else if (start_cond) begin
        state <= ST_DEVADDR;
        bit_count <= 4'h0;
        sda_oe <= 1'b0;
      end else begin
        case (state)
          ST_IDLE: begin
            sda_oe <= 1'b0;
          end
          ST_DEVADDR, ST_RXBYTE: begin
            if (scl_rise) begin
              shift <= {shift[6:0], sda_in};
              bit_count <= bit_count + 4'h1;
            end else if (scl_fall && bit_count == 4'h8) begin
              bit_count <= 4'h0;
              if (state == ST_DEVADDR) begin
                if (shift[7:1] == `RSA_SLAVE_ADDR) begin
                  reading <= shift[0];
                  have_addr <= 1'b0;
                  ack_drive <= 1'b1;
                  state <= ST_ACK;
                  sda_out <= 1'b0;
                  sda_oe <= 1'b1;
                end else begin
                  state <= ST_IDLE;
                end
              end else begin
                state <= ST_ACK;
                sda_out <= 1'b0;
                sda_oe <= 1'b1;
                if (!have_addr) begin
                  have_addr <= 1'b1;
                  ack_drive <= 1'b1;
                  word_address_value <= (shift[4:0] > `RSA_REG_LAST) ? 5'h00 : shift[4:0];
                end else if (buf_in_ready) begin
                  wr_pulse <= 1'b1;
                  wr_addr <= word_address_value;
                  wr_data <= shift;
                end
              end
            end
          end
          ST_ACK: begin
            if (scl_fall) begin
              if (reading) begin
                state <= ST_TXBYTE;
                tx_byte <= user_reg[word_address_value];
                sda_out <= user_reg[word_address_value][7];
                sda_oe <= 1'b1;
                bit_count <= 4'h1;
              end else begin
                state <= ST_RXBYTE;
                sda_oe <= 1'b0;
              end
              ack_drive <= 1'b0;
            end else if (scl_rise && !reading && !ack_drive) begin
              // Only the acknowledge of a data byte steps the pointer
              word_address_value <= ptr_inc(word_address_value);
            end
          end
          ST_TXBYTE: begin
            if (scl_fall) begin
              if (bit_count == 4'h8) begin
                state <= ST_MACK;
                sda_oe <= 1'b0;
              end else begin
                sda_out <= tx_byte[3'd7 - bit_count[2:0]];
                bit_count <= bit_count + 4'h1;
              end
            end
          end
          ST_MACK: begin
            if (scl_rise) begin
              word_address_value <= ptr_inc(word_address_value);
              if (sda_in)
                state <= ST_IDLE;
              else
                state <= ST_MACK;
            end else if (scl_fall && state == ST_MACK) begin
              state <= ST_TXBYTE;
              tx_byte <= user_reg[word_address_value];
              sda_out <= user_reg[word_address_value][7];
              sda_oe <= 1'b1;
              bit_count <= 4'h1;
            end
          end
          default: state <= ST_IDLE;
        endcase
      end
    end
  end

  // ****************************************
  // Timekeeping and register file
  // ****************************************
  // Pointer on a clock address while a transfer is live freezes the user copy
  wire freeze = (state != ST_IDLE) && (word_address_value <= `RSA_ADDR_CLOCK_LAST);
  reg [16:0] div_count;
  reg pending;
  wire halted = user_reg[`RSA_ADDR_SECONDS][`RSA_BIT_HALT];
  wire wr_clock = pop && (buf_addr[buf_rp] <= `RSA_ADDR_CLOCK_LAST);
  // Hundredths tick from the system clock
  wire tick = (div_count == TICK_DIV / 100 - 1);
  wire [7:0] sec_inc = bcd_inc({1'b0, user_reg[1][6:0]});
  wire [7:0] hours_inc = bcd_inc({2'b00, user_reg[3][5:0]});
  integer i;

  always @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      div_count <= 17'd0;
      pending <= 1'b0;
      for (i = 0; i < 20; i = i + 1)
        user_reg[i] <= `RSA_RESET_BYTE;
      user_reg[`RSA_ADDR_DAY] <= 8'h01;
      user_reg[`RSA_ADDR_DATE] <= 8'h01;
      user_reg[`RSA_ADDR_MONTH] <= 8'h01;
    end else begin
      if (wr_clock || halted)
        div_count <= 17'd0;
      else if (tick)
        div_count <= 17'd0;
      else
        div_count <= div_count + 17'd1;
      if (pop) begin
        if (buf_addr[buf_rp] == `RSA_ADDR_SUBSEC) begin
          if (buf_data[buf_rp] == 8'h00)
            user_reg[`RSA_ADDR_SUBSEC] <= 8'h00;
        end else begin
          user_reg[buf_addr[buf_rp]] <= buf_data[buf_rp];
        end
        pending <= 1'b0;
      end else if ((tick || pending) && !halted) begin
        // A tick held back by the freeze is applied once afterwards
        if (freeze)
          pending <= 1'b1;
        else begin
          pending <= 1'b0;
          if (user_reg[0] != 8'h99)
            user_reg[0] <= bcd_inc(user_reg[0]);
          else begin
            user_reg[0] <= 8'h00;
            if (user_reg[1][6:0] != 7'h59)
              user_reg[1] <= {1'b0, sec_inc[6:0]};
            else begin
              user_reg[1] <= 8'h00;
              if (user_reg[2] != 8'h59)
                user_reg[2] <= bcd_inc(user_reg[2]);
              else begin
                user_reg[2] <= 8'h00;
                if (user_reg[3][5:0] != 6'h23)
                  user_reg[3][5:0] <= hours_inc[5:0];
                else begin
                  user_reg[3][5:0] <= 6'h00;
                  user_reg[4] <= (user_reg[4][2:0] == 3'd7) ? 8'h01 : {5'h00, user_reg[4][2:0] + 3'd1};
                  if (user_reg[5] != month_days(user_reg[6], user_reg[7]))
                    user_reg[5] <= bcd_inc(user_reg[5]);
                  else begin
                    user_reg[5] <= 8'h01;
                    if (user_reg[6] != 8'h12)
                      user_reg[6] <= bcd_inc(user_reg[6]);
                    else begin
                      user_reg[6] <= 8'h01;
                      if (user_reg[7] != 8'h99)
                        user_reg[7] <= bcd_inc(user_reg[7]);
                      else begin
                        user_reg[7] <= 8'h00;
                        if (user_reg[3][`RSA_BIT_CENT_EN])
                          user_reg[3][`RSA_BIT_CENT_FLAG] <= ~user_reg[3][`RSA_BIT_CENT_FLAG];
                      end
                    end
                  end
                end
              end
            end
          end
        end
      end
    end
  end

endmodule

// ### inc/rsa_defines.vh
// Constants for the serial register access block of the real-time clock
// Assumes inclusion by bare name from design files
`ifndef RSA_DEFINES_VH
`define RSA_DEFINES_VH
`define RSA_SLAVE_ADDR 7'h68
`define RSA_REG_COUNT 5'h14
`define RSA_REG_LAST 5'h13
`define RSA_ADDR_SUBSEC 5'h00
`define RSA_ADDR_SECONDS 5'h01
`define RSA_ADDR_MINUTES 5'h02
`define RSA_ADDR_CENT_HOURS 5'h03
`define RSA_ADDR_DAY 5'h04
`define RSA_ADDR_DATE 5'h05
`define RSA_ADDR_MONTH 5'h06
`define RSA_ADDR_YEAR 5'h07
`define RSA_ADDR_CLOCK_LAST 5'h07
`define RSA_BIT_HALT 7
`define RSA_BIT_CENT_EN 7
`define RSA_BIT_CENT_FLAG 6
`define RSA_RESET_BYTE 8'h00
`define RSA_TICK_DIV 17'd100000
`define RSA_REC_MS 32'd250
`define RSA_CLK_KHZ 32'd10000
`define RSA_REC_CYCLES (`RSA_REC_MS * `RSA_CLK_KHZ)
`endif

// ### tb/rsa_rtc_serial_asserts.sv
// Port checks for the serial register block
// Assumes binding to rsa_rtc_serial, one clock domain
`timescale 1ns/1ps
module rsa_rtc_serial_chk #(
  parameter REC_CYCLES = 20,
  parameter TICK_DIV = 200
) (
  input wire clock,
  input wire resetn,
  input wire scl_in,
  input wire sda_in,
  input wire supply_low,
  input wire sda_out,
  input wire sda_oe,
  input wire bus_blocked,
  input wire [4:0] word_address_value
);
  reg [31:0] rec_cnt;
  // Cycles since reset release or supply return
  always @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      rec_cnt <= 32'h0;
    end else if (supply_low) begin
      rec_cnt <= 32'h0;
    end else if (rec_cnt != 32'hFFFFFFFF) begin
      rec_cnt <= rec_cnt + 32'h1;
    end
  end
  default clocking @(posedge clock); endclocking
  default disable iff (!resetn);
  blocked_on_low_a: assert property (supply_low |=> bus_blocked)
    else $error("bus not blocked on low supply");
  ptr_cleared_a: assert property (supply_low ##1 supply_low |-> word_address_value == 5'h00)
    else $error("pointer kept on low supply");
  oe_off_blocked_a: assert property (bus_blocked && $past(bus_blocked) |-> !sda_oe)
    else $error("data driven while blocked");
  ptr_range_a: assert property (word_address_value <= 5'h13)
    else $error("pointer beyond last register");
  drive_stable_a: assert property (sda_oe && $past(sda_oe) && scl_in && $past(scl_in) |-> $stable(sda_out))
    else $error("data changed while clock high");
  oe_rise_low_a: assert property ($rose(sda_oe) |-> !scl_in)
    else $error("drive began while clock high");
  oe_fall_low_a: assert property ($fell(sda_oe) && !bus_blocked && !supply_low |-> !scl_in)
    else $error("release while clock high");
  rec_block_a: assert property (rec_cnt < REC_CYCLES |-> bus_blocked)
    else $error("recovery block too short");
  rec_end_a: assert property (rec_cnt > REC_CYCLES + 4 |-> !bus_blocked)
    else $error("recovery block too long");
endmodule

// ### tb/rsa_bus_master.sv
// Two-wire bus master model
// Assumes a pull-up on sda; the model only pulls it low
`timescale 1ns/1ps
module rsa_bus_master #(
  parameter HALF = 4
) (
  input wire clock,
  input wire sda,
  output reg scl,
  output reg sda_low
);
  initial begin
    scl = 1'b1;
    sda_low = 1'b0;
  end
  task wt;
    repeat (HALF) @(posedge clock);
  endtask
  // Also a repeated start when scl is low
  task start;
    begin
      sda_low <= 1'b0;
      wt;
      scl <= 1'b1;
      wt;
      sda_low <= 1'b1;
      wt;
      scl <= 1'b0;
      wt;
    end
  endtask
  task stop;
    begin
      sda_low <= 1'b1;
      wt;
      scl <= 1'b1;
      wt;
      sda_low <= 1'b0;
      wt;
    end
  endtask
  task bit_io(input b, output r);
    begin
      sda_low <= !b;
      wt;
      scl <= 1'b1;
      wt;
      r = sda;
      scl <= 1'b0;
      wt;
    end
  endtask
  task xfer(input [7:0] t, input mack, output [7:0] d, output a);
    integer k;
    reg bb;
    begin
      for (k = 7; k >= 0; k = k - 1) begin
        bit_io(t[k], bb);
        d[k] = bb;
      end
      bit_io(!mack, a);
    end
  endtask
endmodule

// ### tb/test_rsa_rtc_serial.sv
// Self-checking bench for the serial register block
// Assumes the master model and the checker are compiled first
`timescale 1ns/1ps
module test_rsa_rtc_serial;
  localparam REC_CYCLES = 200;
  localparam TICK_DIV = 200;
  reg clock = 1'b0;
  reg resetn = 1'b0;
  reg supply_low = 1'b0;
  wire scl, m_low, sda_out, sda_oe, bus_blocked;
  wire [4:0] ptr;
  wire sda = !(m_low || (sda_oe && !sda_out));
  integer n_mismatch = 0;
  integer checked = 0;
  integer cyc = 0;
  integer i, k;
  reg [7:0] r;
  reg a;
  rsa_bus_master i_rsa_bus_master (.clock(clock), .sda(sda), .scl(scl), .sda_low(m_low));
  rsa_rtc_serial #(.REC_CYCLES(REC_CYCLES), .TICK_DIV(TICK_DIV)) i_rsa_rtc_serial (.clock(clock),
    .resetn(resetn), .scl_in(scl), .sda_in(sda), .supply_low(supply_low), .sda_out(sda_out),
    .sda_oe(sda_oe), .bus_blocked(bus_blocked), .word_address_value(ptr));
  initial begin
    forever #50 clock = !clock;
  end
  always @(posedge clock) begin
    cyc = cyc + 1;
    if (cyc == 20000) begin
      n_mismatch = n_mismatch + 1;
      stop_test;
    end
  end
  task chk(input [8*8-1:0] what, input [7:0] exp, input [7:0] got);
    begin
      checked = checked + 1;
      if (got !== exp) begin
        n_mismatch = n_mismatch + 1;
        $display("mismatch %0s expected %h seen %h", what, exp, got);
      end
    end
  endtask
  task tx(input [7:0] b, input ex);
    begin
      i_rsa_bus_master.xfer(b, 1'b0, r, a);
      chk("ack", {7'h0, ex}, {7'h0, !a});
    end
  endtask
  task rx(input [7:0] ex, input mack);
    begin
      i_rsa_bus_master.xfer(8'hFF, mack, r, a);
      chk("data", ex, r);
    end
  endtask
  task setp(input [7:0] ad);
    begin
      i_rsa_bus_master.start;
      tx(8'hD0, 1'b1);
      tx(ad, 1'b1);
    end
  endtask
  task waitfree;
    begin
      i = 0;
      while (bus_blocked !== 1'b0 && i < 1000) begin
        @(posedge clock);
        i = i + 1;
      end
      chk("blocked", 8'h00, {7'h0, bus_blocked});
    end
  endtask
  task stop_test;
    begin
      $display("mismatches %0d checks %0d", n_mismatch, checked);
      if (n_mismatch == 0 && checked > 0) begin
        $display("Finished cleanly");
      end else begin
        $display("Finished with errors");
      end
      $finish;
    end
  endtask
  // ****************
  // Test sequence
  // ****************
  initial begin
    repeat (2) @(posedge clock);
    resetn <= 1'b1;
    waitfree;
    setp(8'h00);
    tx(8'h00, 1'b1);
    tx(8'h80, 1'b1);
    tx(8'h42, 1'b1);
    chk("ptr", 8'h03, {3'h0, ptr});
    i_rsa_bus_master.stop;
    setp(8'h00);
    tx(8'h55, 1'b1);
    i_rsa_bus_master.stop;
    setp(8'h00);
    i_rsa_bus_master.start;
    tx(8'hD1, 1'b1);
    rx(8'h00, 1'b1);
    rx(8'h80, 1'b0);
    i_rsa_bus_master.stop;
    chk("ptr", 8'h02, {3'h0, ptr});
    i_rsa_bus_master.start;
    tx(8'hD1, 1'b1);
    rx(8'h42, 1'b0);
    i_rsa_bus_master.stop;
    for (k = 0; k < 2; k = k + 1) begin
      setp(8'h00);
      tx(8'h00, 1'b1);
      tx(8'h59, 1'b1);
      tx(8'h59, 1'b1);
      tx({k[0], 1'b0, 6'h23}, 1'b1);
      tx(8'h07, 1'b1);
      tx(8'h31, 1'b1);
      tx(8'h12, 1'b1);
      tx(8'h99, 1'b1);
      i_rsa_bus_master.stop;
      repeat (300) @(posedge clock);
      setp(8'h03);
      i_rsa_bus_master.start;
      tx(8'hD1, 1'b1);
      rx({k[0], k[0], 6'h00}, 1'b1);
      rx(8'h01, 1'b1);
      rx(8'h01, 1'b1);
      rx(8'h01, 1'b1);
      rx(8'h00, 1'b0);
      i_rsa_bus_master.stop;
    end
    i_rsa_bus_master.start;
    tx(8'hA0, 1'b0);
    i_rsa_bus_master.stop;
    setp(8'h13);
    tx(8'h00, 1'b1);
    chk("ptr", 8'h00, {3'h0, ptr});
    i_rsa_bus_master.stop;
    setp(8'h05);
    supply_low <= 1'b1;
    repeat (3) @(posedge clock);
    chk("ptr", 8'h00, {3'h0, ptr});
    chk("blocked", 8'h01, {7'h0, bus_blocked});
    i_rsa_bus_master.stop;
    supply_low <= 1'b0;
    i_rsa_bus_master.start;
    tx(8'hD0, 1'b0);
    i_rsa_bus_master.stop;
    waitfree;
    i_rsa_bus_master.start;
    tx(8'hD0, 1'b1);
    i_rsa_bus_master.stop;
    stop_test;
  end
endmodule
bind rsa_rtc_serial rsa_rtc_serial_chk #(.REC_CYCLES(REC_CYCLES), .TICK_DIV(TICK_DIV)) i_rsa_rtc_serial_chk (
  .clock(clock), .resetn(resetn), .scl_in(scl_in), .sda_in(sda_in), .supply_low(supply_low),
  .sda_out(sda_out), .sda_oe(sda_oe), .bus_blocked(bus_blocked), .word_address_value(word_address_value));
